// [hdl/blank_chop_pkg.sv]
// Shared constants, register layouts and selector decoding
package blank_chop_pkg;

  // ==========================================================
  // Register word indexes (byte offsets 0x0, 0x4, 0x8)
  localparam logic [1:0] IDX_CTRL  = 2'h0;
  localparam logic [1:0] IDX_DELAY = 2'h1;
  localparam logic [1:0] IDX_AUX   = 2'h2;

  // ==========================================================
  // Reset values and writable bit masks
  localparam logic [15:0] CTRL_RESET  = 16'h0000;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam logic [15:0] AUX_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WMASK  = 16'hfc3f;
  localparam logic [15:0] DELAY_WMASK = 16'h0ff8;
  localparam logic [15:0] AUX_WMASK   = 16'hcf3f;

  // ==========================================================
  // Field positions
  localparam int DELAY_LSB = 3;
  localparam int DELAY_MSB = 11;
  localparam int DELAY_W   = 9;
  localparam int SEL_W     = 4;
  localparam int GEN_COUNT = 9;
  localparam int CNT_W     = 12;

  // ==========================================================
  // Timing
  localparam int STEP_PS     = 8320;
  localparam int CLK_PS      = 100000;
  localparam int STEP_CYCLES = (STEP_PS + CLK_PS - 1) / CLK_PS < 1 ? 1 :
                               (STEP_PS + CLK_PS - 1) / CLK_PS;

  // ==========================================================
  // Register layouts
  typedef struct packed {
    logic       highRiseTriggerEn;
    logic       highFallTriggerEn;
    logic       lowRiseTriggerEn;
    logic       lowFallTriggerEn;
    logic       faultBlankEn;
    logic       curlimBlankEn;
    logic [3:0] unused;
    logic       blankOnSignalHigh;
    logic       blankOnSignalLow;
    logic       blankHighSideHigh;
    logic       blankHighSideLow;
    logic       blankLowSideHigh;
    logic       blankLowSideLow;
  } blank_ctrl_s;

  typedef struct packed {
    logic             hiresPeriodOff;
    logic             hiresDutyOff;
    logic [1:0]       unusedHigh;
    logic [SEL_W-1:0] blankSourceSelect;
    logic [1:0]       unusedLow;
    logic [SEL_W-1:0] chopSourceSelect;
    logic             highChopEn;
    logic             lowChopEn;
  } aux_ctrl_s;

  typedef enum logic [1:0] {
    LEB_IDLE = 2'b01,
    LEB_RUN  = 2'b10
  } leb_state_e;

  // Code 0 picks the fallback, 1..9 a generator, others read low
  function automatic logic pick_source(
    input logic [SEL_W-1:0]     code,
    input logic [GEN_COUNT-1:0] peers,
    input logic                 fallback
  );
    logic r;
    r = 1'b0;
    if (code == 4'h0) begin
      r = fallback;
    end else if (code <= 4'h9) begin
      r = peers[code - 4'h1];
    end
    return r;
  endfunction

endpackage

// [hdl/pin_sync.sv]
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1;

  // ==========================================================
  // Per-bit flop pair
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        stage1[i]  <= 1'b0;
        syncOut[i] <= 1'b0;
      end else begin
        stage1[i]  <= pinIn[i];
        syncOut[i] <= stage1[i];
      end
    end
  end

endmodule // pin_sync

// [hdl/blank_timer.sv]
// Leading-edge blanking counter
`timescale 1ns/1ns
module blank_timer
  import blank_chop_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  input  wire logic               trigger,
  input  wire logic               tick,
  input  wire logic [DELAY_W-1:0] delay,
  output logic                    active
);

  leb_state_e       state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] target;
  logic             done;

  assign target = CNT_W'(delay * STEP_CYCLES);
  assign done   = tick && (count + 12'h001 >= target);
  assign active = state[1];

  // ==========================================================
  // Counter and state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= LEB_IDLE;
      count <= 12'h000;
    end else begin
      case (state)
        LEB_IDLE: begin
          if (trigger && target != 12'h000) begin
            state <= LEB_RUN;
            count <= 12'h000;
          end
        end
        LEB_RUN: begin
          if (trigger) begin
            count <= 12'h000;
          end else if (done) begin
            state <= LEB_IDLE;
          end else if (tick) begin
            count <= count + 12'h001;
          end
        end
        default: begin
          state <= LEB_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Checks
  chk_blank_length: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state == LEB_RUN && !trigger && done |=> state == LEB_IDLE)
    else $error("blanking did not end at programmed delay");

  chk_blank_restart: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state == LEB_RUN && trigger |=> count == 12'h000 && active)
    else $error("trigger did not restart blanking count");

endmodule // blank_timer

// [hdl/pwm_blanking_and_chop_control.sv]
// PWM blanking, state blanking and chop control with Avalon-MM registers
//
// Functional notes
// - High-side edges start blanking when enabled
// - Low-side edges start blanking when enabled
// - Fault input blanked only when enabled
// - Current-limit input blanked only when enabled
// - Delay field bits 11:3, one step each
// - Delay counter advances on prescaled clock
// - Block inputs while selected signal high
// - Block inputs while selected signal low
// - Block inputs while high side high
// - Block inputs while high side low
// - Block inputs while low side high
// - Block inputs while low side low
// - Blank source code picks generator, zero none
// - Selected signal blanks only when enabled
// - Chop source code zero is internal clock
// - High-side output gated by chop clock
// - Low-side output gated by chop clock
// - Period disable bit turns off hires period
// - Duty disable bit turns off hires duty
// - Unimplemented register bits read zero
`timescale 1ns/1ns
module pwm_blanking_and_chop_control
  import blank_chop_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // Avalon-MM slave
  input  wire logic [1:0]           address,
  input  wire logic                 read,
  input  wire logic                 write,
  input  wire logic [31:0]          writedata,
  input  wire logic [3:0]           byteenable,
  output logic      [31:0]          readdata,
  output logic                      waitrequest,
  // PWM core side
  input  wire logic                 pwmHighIn,
  input  wire logic                 pwmLowIn,
  input  wire logic [GEN_COUNT-1:0] peerHighSide,
  input  wire logic                 chopClockGen,
  input  wire logic                 prescaleTick,
  // Protection inputs from pins
  input  wire logic                 faultIn,
  input  wire logic                 curlimIn,
  // Outputs
  output logic                      highSideOutput,
  output logic                      lowSideOutput,
  output logic                      faultOut,
  output logic                      curlimOut,
  output logic                      hiresPeriodOff,
  output logic                      hiresDutyOff
);

  // ==========================================================
  // Declarations
  blank_ctrl_s        ctrl;
  aux_ctrl_s          aux;
  logic [15:0]        delayReg;
  logic [DELAY_W-1:0] delayField;
  logic [1:0]         pinSync;
  logic               faultSync;
  logic               curlimSync;
  logic               prevHigh;
  logic               prevLow;
  logic               highRise;
  logic               highFall;
  logic               lowRise;
  logic               lowFall;
  logic               trig;
  logic               lebActive;
  logic               blankSig;
  logic               blankSigLow;
  logic               chopSig;
  logic               stateBlank;
  logic               faultBlock;
  logic               curlimBlock;
  logic               accept;
  logic [15:0]        next_readdata;

  // ==========================================================
  // Write merge with byte enables and writable mask
  function automatic logic [15:0] merge(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be,
    input logic [15:0] mask
  );
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r & mask;
  endfunction

  // ==========================================================
  // Bus handshake: one wait cycle, then the access completes
  assign accept = !waitrequest && (read || write);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else if (waitrequest && (read || write)) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl     <= CTRL_RESET;
      delayReg <= DELAY_RESET;
      aux      <= AUX_RESET;
    end else if (accept && write) begin
      case (address)
        IDX_CTRL:  ctrl     <= merge(ctrl, writedata, byteenable,
                                     CTRL_WMASK);
        IDX_DELAY: delayReg <= merge(delayReg, writedata, byteenable,
                                     DELAY_WMASK);
        IDX_AUX:   aux      <= merge(aux, writedata, byteenable,
                                     AUX_WMASK);
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Read data, unmapped reads return zero
  always_comb begin
    case (address)
      IDX_CTRL:  next_readdata = ctrl & CTRL_WMASK;
      IDX_DELAY: next_readdata = delayReg & DELAY_WMASK;
      IDX_AUX:   next_readdata = aux & AUX_WMASK;
      default:   next_readdata = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (waitrequest && read) begin
      readdata <= {16'h0000, next_readdata};
    end
  end

  // ==========================================================
  // Pin synchronisers
  pin_sync #(
    .W (2)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pinIn   ({faultIn, curlimIn}),
    .syncOut (pinSync)
  );

  assign faultSync  = pinSync[1];
  assign curlimSync = pinSync[0];

  // ==========================================================
  // Edge detection and blanking trigger
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prevHigh <= 1'b0;
      prevLow  <= 1'b0;
    end else begin
      prevHigh <= pwmHighIn;
      prevLow  <= pwmLowIn;
    end
  end

  assign highRise = pwmHighIn && !prevHigh;
  assign highFall = !pwmHighIn && prevHigh;
  assign lowRise  = pwmLowIn && !prevLow;
  assign lowFall  = !pwmLowIn && prevLow;

  assign trig = (highRise && ctrl.highRiseTriggerEn)
             || (highFall && ctrl.highFallTriggerEn)
             || (lowRise && ctrl.lowRiseTriggerEn)
             || (lowFall && ctrl.lowFallTriggerEn);

  assign delayField = delayReg[DELAY_MSB:DELAY_LSB];

  blank_timer u_blank_timer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .trigger (trig),
    .tick    (prescaleTick),
    .delay   (delayField),
    .active  (lebActive)
  );

  // ==========================================================
  // State blanking
  assign blankSig = pick_source(aux.blankSourceSelect, peerHighSide,
                                1'b0);

  // Code zero means no selected-signal blanking at all, low level included
  assign blankSigLow = !blankSig
                    && aux.blankSourceSelect != 4'h0;

  assign stateBlank = (ctrl.blankOnSignalHigh && blankSig)
                   || (ctrl.blankOnSignalLow && blankSigLow)
                   || (ctrl.blankHighSideHigh && pwmHighIn)
                   || (ctrl.blankHighSideLow && !pwmHighIn)
                   || (ctrl.blankLowSideHigh && pwmLowIn)
                   || (ctrl.blankLowSideLow && !pwmLowIn);

  assign faultBlock  = ctrl.faultBlankEn
                    && (lebActive || stateBlank);
  assign curlimBlock = ctrl.curlimBlankEn
                    && (lebActive || stateBlank);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      faultOut  <= 1'b0;
      curlimOut <= 1'b0;
    end else begin
      faultOut  <= faultSync && !faultBlock;
      curlimOut <= curlimSync && !curlimBlock;
    end
  end

  // ==========================================================
  // Chopping
  assign chopSig = pick_source(aux.chopSourceSelect, peerHighSide,
                               chopClockGen);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      highSideOutput <= 1'b0;
      lowSideOutput  <= 1'b0;
    end else begin
      highSideOutput <= pwmHighIn
                     && (!aux.highChopEn || chopSig);
      lowSideOutput  <= pwmLowIn
                     && (!aux.lowChopEn || chopSig);
    end
  end

  // ==========================================================
  // High-resolution disables
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      hiresPeriodOff <= 1'b0;
      hiresDutyOff   <= 1'b0;
    end else begin
      hiresPeriodOff <= aux.hiresPeriodOff;
      hiresDutyOff   <= aux.hiresDutyOff;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  chk_rise_trigger: assert property (
    $rose(pwmHighIn) && ctrl.highRiseTriggerEn && delayField != 9'h000
    |=> lebActive)
    else $error("high rise did not start blanking");

  chk_fall_ignored: assert property (
    !lebActive && $fell(pwmHighIn) && !ctrl.highFallTriggerEn
    && !(ctrl.lowRiseTriggerEn || ctrl.lowFallTriggerEn)
    |=> !lebActive)
    else $error("disabled high fall started blanking");

  chk_low_trigger: assert property (
    ($rose(pwmLowIn) && ctrl.lowRiseTriggerEn
     || $fell(pwmLowIn) && ctrl.lowFallTriggerEn)
    && delayField != 9'h000 |=> lebActive)
    else $error("low edge did not start blanking");

  chk_fault_pass: assert property (
    !ctrl.faultBlankEn |=> faultOut == $past(faultSync))
    else $error("unblanked fault input altered");

  chk_curlim_mask: assert property (
    ctrl.curlimBlankEn && lebActive |=> !curlimOut)
    else $error("current limit passed during blanking");

  chk_signal_blank: assert property (
    ctrl.faultBlankEn && ctrl.blankOnSignalHigh && blankSig
    |=> !faultOut)
    else $error("fault passed while blank signal high");

  chk_side_blank: assert property (
    ctrl.curlimBlankEn && ctrl.blankLowSideLow && !pwmLowIn
    |=> !curlimOut)
    else $error("current limit passed while low side low");

  chk_no_source: assert property (
    aux.blankSourceSelect == 4'h0 && !ctrl.blankOnSignalLow
    && !lebActive && ctrl.blankOnSignalHigh
    && !(ctrl.blankHighSideHigh || ctrl.blankHighSideLow
         || ctrl.blankLowSideHigh || ctrl.blankLowSideLow)
    |=> curlimOut == $past(curlimSync))
    else $error("code zero produced state blanking");

  chk_zero_source: assert property (
    aux.blankSourceSelect == 4'h0 && !lebActive
    && !(ctrl.blankHighSideHigh || ctrl.blankHighSideLow
         || ctrl.blankLowSideHigh || ctrl.blankLowSideLow)
    |=> faultOut == $past(faultSync))
    else $error("blank source zero blocked fault input");

  chk_signal_low: assert property (
    ctrl.curlimBlankEn && ctrl.blankOnSignalLow && blankSigLow
    |=> !curlimOut)
    else $error("current limit passed while blank signal low");

  chk_high_low: assert property (
    ctrl.faultBlankEn && ctrl.blankHighSideLow && !pwmHighIn
    |=> !faultOut)
    else $error("fault passed while high side low");

  chk_duty_off: assert property (
    aux.hiresDutyOff |=> hiresDutyOff)
    else $error("duty disable not applied");

  chk_chop_gate: assert property (
    aux.highChopEn && !chopSig |=> !highSideOutput)
    else $error("high side not chopped");

  chk_low_plain: assert property (
    !aux.lowChopEn |=> lowSideOutput == $past(pwmLowIn))
    else $error("low side altered without chopping");

  chk_hires_off: assert property (
    $rose(aux.hiresPeriodOff) |=> hiresPeriodOff ##1 hiresPeriodOff
    || $fell(aux.hiresPeriodOff))
    else $error("period disable not applied");

  chk_read_zero: assert property (
    read && waitrequest && address == IDX_AUX
    |=> readdata[13:12] == 2'h0 && readdata[7:6] == 2'h0
        && readdata[31:16] == 16'h0000)
    else $error("unimplemented aux bits read nonzero");

  chk_bus_answer: assert property (
    (read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");

  cov_leb_run: cover property (
    trig ##1 lebActive [*3] ##1 !lebActive);

  cov_state_blank: cover property (
    stateBlank && curlimSync && ctrl.curlimBlankEn);

  cov_chop_ext: cover property (
    aux.highChopEn && aux.chopSourceSelect == 4'h9 && highSideOutput);

endmodule // pwm_blanking_and_chop_control

// [verification/power_stage_model.sv]
// Power stage and fault source model facing the PWM outputs
`timescale 1ns/1ns
module power_stage_model #(
  parameter int SPIKE_LEN = 6
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic highSideOutput,
  input  wire logic spikeEn,
  input  wire logic faultReq,
  input  wire logic curlimReq,
  output logic      faultIn,
  output logic      curlimIn
);
  // ==========================================================
  // Switching spike on each high-side turn-on
  logic       lastHigh;
  logic [3:0] spikeLeft;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lastHigh  <= 1'h0;
      spikeLeft <= 4'h0;
    end else begin
      lastHigh <= highSideOutput;
      if (spikeEn && highSideOutput && !lastHigh)
        spikeLeft <= 4'(SPIKE_LEN);
      else if (spikeLeft != 4'h0)
        spikeLeft <= spikeLeft - 4'h1;
    end
  end

  assign faultIn  = faultReq;
  assign curlimIn = curlimReq || (spikeLeft != 4'h0);
endmodule // power_stage_model

// [verification/pwm_blanking_and_chop_control_tb.sv]
// Self-checking bench for the blanking and chop block
`timescale 1ns/1ns
module pwm_blanking_and_chop_control_tb;
  import blank_chop_pkg::*;
  // ==========================================================
  // Signals
  logic       sys_clk, nrst, read, write, waitrequest;
  logic [1:0] address, tickDiv;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [8:0] peerHighSide;
  logic       pwmHighIn, pwmLowIn, chopClockGen, prescaleTick;
  logic       faultIn, curlimIn, faultOut, curlimOut;
  logic       highSideOutput, lowSideOutput;
  logic       hiresPeriodOff, hiresDutyOff;
  logic       faultReq, curlimReq, spikeEn;
  int         errCount, nCompared, cycles;

  pwm_blanking_and_chop_control i_pwm_blanking_and_chop_control (
    .sys_clk(sys_clk), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .pwmHighIn(pwmHighIn), .pwmLowIn(pwmLowIn),
    .peerHighSide(peerHighSide), .chopClockGen(chopClockGen),
    .prescaleTick(prescaleTick), .faultIn(faultIn), .curlimIn(curlimIn),
    .highSideOutput(highSideOutput), .lowSideOutput(lowSideOutput),
    .faultOut(faultOut), .curlimOut(curlimOut),
    .hiresPeriodOff(hiresPeriodOff), .hiresDutyOff(hiresDutyOff));

  power_stage_model i_power_stage_model (
    .sys_clk(sys_clk), .nrst(nrst), .highSideOutput(highSideOutput),
    .spikeEn(spikeEn), .faultReq(faultReq), .curlimReq(curlimReq),
    .faultIn(faultIn), .curlimIn(curlimIn));

  // ==========================================================
  // Clock, prescaler tick and watchdog
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    tickDiv <= tickDiv + 2'h1;
    prescaleTick <= (tickDiv == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errCount++;
      summarize;
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic summarize;
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      errCount++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [15:0] d, input logic [3:0] be,
                     output logic [15:0] q);
    @(posedge sys_clk);
    address <= a;
    writedata <= {16'h0000, d};
    byteenable <= be;
    read <= !wr;
    write <= wr;
    do @(posedge sys_clk); while (waitrequest !== 1'h0);
    q = readdata[15:0];
    read <= 1'h0;
    write <= 1'h0;
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d,
                    input logic [3:0] be = 4'hf);
    logic [15:0] q;
    bus(1'h1, a, d, be, q);
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'h0, a, 16'h0000, 4'hf, q);
    chk(q, e);
  endtask

  task automatic outs(input logic f, input logic c);
    chk({14'h0, faultOut, curlimOut}, {14'h0, f, c});
  endtask

  task automatic setPin(input logic h, input logic v);
    if (h)
      pwmHighIn <= v;
    else
      pwmLowIn <= v;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 4; i++) rd_chk(2'(i), 16'h0000);
    for (int i = 0; i < 4; i++) wr(2'(i), 16'hffff);
    rd_chk(IDX_CTRL, 16'hfc3f);
    rd_chk(IDX_DELAY, 16'h0ff8);
    rd_chk(IDX_AUX, 16'hcf3f);
    rd_chk(2'h3, 16'h0000);
    wr(IDX_CTRL, 16'h0000, 4'h1);
    rd_chk(IDX_CTRL, 16'hfc00);
    for (int i = 0; i < 3; i++) wr(2'(i), 16'h0000);
  endtask

  task automatic t_hires;
    for (int i = 0; i < 4; i++) begin
      wr(IDX_AUX, {2'(i), 14'h0});
      cyc(2);
      chk({14'h0, hiresPeriodOff, hiresDutyOff}, 16'(i));
    end
  endtask

  task automatic t_chop;
    logic [8:0] m;
    pwmHighIn <= 1'h1;
    pwmLowIn <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      m = (i == 0) ? 9'h000 : 9'h001 << (i - 1);
      wr(IDX_AUX, {10'h0, 4'(i), 2'h3});
      for (int s = 0; s < 2; s++) begin
        chopClockGen <= (i == 0) ? s[0] : !s[0];
        peerHighSide <= s[0] ? m : ~m;
        cyc(3);
        chk({14'h0, highSideOutput, lowSideOutput}, 16'(s * 3));
      end
    end
    chopClockGen <= 1'h0;
    wr(IDX_AUX, 16'h0002);
    cyc(3);
    chk({14'h0, highSideOutput, lowSideOutput}, 16'h0001);
    wr(IDX_AUX, 16'h0001);
    cyc(3);
    chk({14'h0, highSideOutput, lowSideOutput}, 16'h0002);
  endtask

  task automatic t_state;
    for (int b = 0; b < 4; b++) begin
      wr(IDX_CTRL, 16'h0c00 | (16'h0001 << b));
      for (int s = 0; s < 2; s++) begin
        setPin(b >= 2, b[0] ^ s[0]);
        cyc(6);
        outs(s[0], s[0]);
      end
    end
    pwmHighIn <= 1'h0;
    pwmLowIn <= 1'h1;
    wr(IDX_CTRL, 16'h080a);
    cyc(6);
    outs(1'h0, 1'h1);
    wr(IDX_CTRL, 16'h0405);
    cyc(6);
    outs(1'h1, 1'h0);
  endtask

  task automatic t_select;
    logic [8:0] m;
    for (int i = 0; i < 10; i++) begin
      m = (i == 0) ? 9'h000 : 9'h001 << (i - 1);
      wr(IDX_AUX, {4'h0, 4'(i), 8'h00});
      wr(IDX_CTRL, 16'h0c20);
      peerHighSide <= m;
      cyc(6);
      outs(1'(i == 0), 1'(i == 0));
      peerHighSide <= ~m;
      cyc(6);
      outs(1'h1, 1'h1);
      wr(IDX_CTRL, 16'h0c10);
      cyc(6);
      outs(1'(i == 0), 1'(i == 0));
      wr(IDX_CTRL, 16'h0c00);
      cyc(6);
      outs(1'h1, 1'h1);
    end
  endtask

  task automatic t_leb;
    wr(IDX_DELAY, 16'h0020);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CTRL, 16'h0c00);
      setPin(i < 2, i[0]);
      wr(IDX_CTRL, 16'h0c00 | (16'h8000 >> i));
      cyc(6);
      outs(1'h1, 1'h1);
      setPin(i < 2, !i[0]);
      cyc(5);
      outs(1'h0, 1'h0);
      cyc(5);
      outs(1'h0, 1'h0);
      cyc(20);
      outs(1'h1, 1'h1);
      setPin(i < 2, i[0]);
      cyc(5);
      outs(1'h1, 1'h1);
    end
    wr(IDX_CTRL, 16'hcc00);
    setPin(1'h1, 1'h0);
    cyc(12);
    setPin(1'h1, 1'h1);
    cyc(10);
    outs(1'h0, 1'h0);
    cyc(30);
    outs(1'h1, 1'h1);
  endtask

  task automatic t_spike;
    int seen;
    faultReq <= 1'h0;
    curlimReq <= 1'h0;
    spikeEn <= 1'h1;
    for (int e = 0; e < 2; e++) begin
      wr(IDX_CTRL, (e != 0) ? 16'h8000 : 16'h8400);
      setPin(1'h1, 1'h0);
      cyc(20);
      setPin(1'h1, 1'h1);
      seen = 0;
      repeat (20) begin
        @(posedge sys_clk);
        if (curlimOut !== 1'h0) seen++;
      end
      chk(16'(seen != 0), 16'(e));
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'h0;
    address = 2'h0;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0;
    byteenable = 4'hf;
    pwmHighIn = 1'h0;
    pwmLowIn = 1'h0;
    peerHighSide = 9'h000;
    chopClockGen = 1'h0;
    tickDiv = 2'h0;
    prescaleTick = 1'h0;
    faultReq = 1'h1;
    curlimReq = 1'h1;
    spikeEn = 1'h0;
    repeat (10) @(posedge sys_clk);
    chk({12'h0, waitrequest, highSideOutput, faultOut, curlimOut}, 16'h0008);
    nrst <= 1'h1;
    t_regs;
    t_hires;
    t_chop;
    t_state;
    t_select;
    t_leb;
    t_spike;
    summarize;
  end
endmodule // pwm_blanking_and_chop_control_tb
